// ---- inc/homing_pkg.sv ----
// constants and types shared by the limit-plus-index homing sequencer
package homing_pkg;
  // command codes on the network command link
  localparam logic [7:0]  CMD_NORMAL       = 8'h10;
  localparam logic [7:0]  CMD_PROFILE_START = 8'h17;
  // profile type code that selects limit-plus-index homing
  localparam logic [7:0]  TYPE_LIMIT_INDEX = 8'h36;
  // command error code for an illegal mode change mid-sequence
  localparam logic [15:0] ERR_MODE_CHANGE  = 16'h0104;
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  // register offsets on the plain register port
  localparam logic [3:0]  OFS_CTRL     = 4'h0;  // command and type codes
  localparam logic [3:0]  OFS_LATCH    = 4'h1;  // first latch selector, monitor selector
  localparam logic [3:0]  OFS_ACCEL    = 4'h2;  // acceleration constant
  localparam logic [3:0]  OFS_DECEL    = 4'h3;  // deceleration constant
  localparam logic [3:0]  OFS_VEL1     = 4'h4;  // homing velocity one
  localparam logic [3:0]  OFS_VEL2     = 4'h5;  // homing velocity two
  localparam logic [3:0]  OFS_DIR      = 4'h6;  // homing direction setting
  localparam logic [3:0]  OFS_STATUS   = 4'h7;  // echoes and status flags
  localparam logic [3:0]  OFS_POSITION = 4'h8;  // position counter
  localparam logic [3:0]  OFS_MONITOR  = 4'h9;  // monitor data
  localparam logic [3:0]  OFS_ERRCODE  = 4'hA;  // command error code
  // status field positions
  localparam int ST_IN_PROGRESS = 16;
  localparam int ST_COMPLETE    = 17;
  localparam int ST_CMD_ERROR   = 18;
  localparam int ST_HOME_ERROR  = 19;
  localparam int ST_NET_ERROR   = 20;
  // reset values of the speed constants
  localparam logic [15:0] ACCEL_RESET = 16'h0001;
  localparam logic [15:0] DECEL_RESET = 16'h0001;
  localparam logic [15:0] VEL1_RESET  = 16'h0100;
  localparam logic [15:0] VEL2_RESET  = 16'h0010;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN_OUT, ST_BRAKE, ST_RUN_BACK, ST_SEEK_INDEX, ST_REPOSITION, ST_DONE
  } seq_state_e;
endpackage

// ---- hdl/speed_ramp.sv ----
// signed speed ramp: steps toward a target speed by accel or decel constant
`timescale 1ns/100ps
`default_nettype none
module speed_ramp
  import homing_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n_sync,
  input  wire logic signed [17:0] target,
  input  wire logic [15:0]        accel,
  input  wire logic [15:0]        decel,
  output logic signed [17:0]      speed,
  output logic                    stopped
);
  logic signed [18:0] up_sum;     // speed plus step, one bit wider
  logic signed [18:0] dn_sum;     // speed minus step
  logic        [15:0] step;       // accel when growing magnitude, else decel
  logic               growing;    // moving away from zero
  // speeding up uses accel, slowing toward zero uses decel
  always_comb begin
    growing = (target > speed) ? (speed >= 18'sd0) : (speed <= 18'sd0);
    step    = growing ? accel : decel;
    up_sum  = 19'(speed) + 19'(signed'({1'b0, step}));
    dn_sum  = 19'(speed) - 19'(signed'({1'b0, step}));
  end
  // clamp so the ramp lands exactly on the target, never overshoots
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      speed <= '0;
    end else if (target > speed) begin
      speed <= (up_sum > 19'(target)) ? target : up_sum[17:0];
    end else if (target < speed) begin
      speed <= (dn_sum < 19'(target)) ? target : dn_sum[17:0];
    end
  end
  assign stopped = (speed == 18'sd0);
endmodule // speed_ramp
`default_nettype wire

// ---- hdl/homing_sequencer.sv ----
// limit-plus-index homing sequencer of a servo drive with a register port
// Contract
// - normal command code alone starts nothing
// - start edge: run away at velocity one
// - clear homing complete at start
// - far limit: decelerate to stop
// - stopped at limit: return at velocity two
// - only index after limit released counts
// - stop on first index, reposition onto it
// - zero position at index, set complete
// - direction setting zero means positive homing
// - ignore overtravel config during homing
// - wrong-side or both limits: error, cancel
// - other commands run during homing
// - mode change mid-homing: command error 0104h
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module homing_sequencer
  import homing_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        positive_limit_sensor,
  input  wire logic        negative_limit_sensor,
  input  wire logic        index_pulse,
  input  wire logic        overtravel_inhibit_config,
  input  wire logic        overtravel_stop_sequence,
  output logic signed [17:0] motor_speed,
  output logic             homing_error_protection,
  output logic             network_command_error_protection
);
  logic        rst_meta_reg;         // reset synchroniser stage one
  logic        rst_n_sync;           // released reset used everywhere
  logic [7:0]  cmd_code_reg;         // command code from host
  logic [7:0]  type_code_reg;        // profile type code
  logic [7:0]  first_latch_selector; // latch selector from host
  logic [7:0]  monitor_sel_reg;      // which quantity the monitor returns
  logic [15:0] acceleration_constant;
  logic [15:0] deceleration_constant;
  logic [15:0] homing_velocity_one;
  logic [15:0] homing_velocity_two;
  logic        homing_direction_setting; // 0 = positive homing
  logic [7:0]  type_at_start_reg;    // type latched when sequence started
  logic [7:0]  latch_at_start_reg;   // latch selector latched at start
  logic        in_progress_reg;
  logic        complete_reg;
  logic        cmd_error_reg;
  logic [15:0] err_code_reg;
  logic signed [31:0] position_reg;  // integrated motor position
  logic signed [31:0] index_pos_reg; // position captured at the index
  logic        limit_released_reg;   // far limit let go after reversal
  logic        start_pulse;          // 10h to 17h edge with homing type
  logic        ctrl_write;
  logic        mode_change;          // illegal type or latch write
  logic        far_limit;            // limit opposite the homing direction
  logic        near_limit;           // limit on the homing side
  logic signed [17:0] ramp_target;
  logic signed [17:0] ramp_speed;
  logic        ramp_stopped;
  logic signed [17:0] v1_signed;
  logic signed [17:0] v2_signed;
  logic signed [31:0] pos_err;       // remaining distance to index
  logic        [15:0] creep_lim;     // largest hop the ramp starts and sheds in one step
  logic        [31:0] err_mag;       // distance to the index, unsigned
  logic signed [17:0] creep_speed;   // signed speed of the next repositioning hop
  seq_state_e  state_reg;

  // two-flop reset release; assertion is still immediate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  assign ctrl_write = reg_wr && (reg_addr == OFS_CTRL);
  // code 10h on its own never moves the motor; likewise for the type
  assign start_pulse = ctrl_write && (cmd_code_reg == CMD_NORMAL)
                    && (reg_wdata[7:0] == CMD_PROFILE_START)
                    && (reg_wdata[15:8] == TYPE_LIMIT_INDEX) && !in_progress_reg;
  assign mode_change = in_progress_reg && reg_wr
                    && (((reg_addr == OFS_CTRL) && (reg_wdata[15:8] != type_at_start_reg))
                     || ((reg_addr == OFS_LATCH) && (reg_wdata[7:0] != latch_at_start_reg)));

  // direction select: zero means homing toward positive
  assign far_limit  = homing_direction_setting ? positive_limit_sensor
                                               : negative_limit_sensor;
  assign near_limit = homing_direction_setting ? negative_limit_sensor
                                               : positive_limit_sensor;
  // run-out is opposite to homing direction; return is toward it
  assign v1_signed = homing_direction_setting ? 18'(signed'({2'b00, homing_velocity_one}))
                                              : -18'(signed'({2'b00, homing_velocity_one}));
  assign v2_signed = homing_direction_setting ? -18'(signed'({2'b00, homing_velocity_two}))
                                              : 18'(signed'({2'b00, homing_velocity_two}));
  assign pos_err = index_pos_reg - position_reg;

  // short hops land exactly on the index; a steady crawl would hunt around it
  // limitation: a zero accel or decel constant stalls the hops
  always_comb begin
    creep_lim = homing_velocity_two;
    if (acceleration_constant < creep_lim) creep_lim = acceleration_constant;
    if (deceleration_constant < creep_lim) creep_lim = deceleration_constant;
    err_mag     = (pos_err < 32'sd0) ? 32'(-pos_err) : 32'(pos_err);
    creep_speed = (err_mag < 32'(creep_lim)) ? 18'(err_mag) : 18'({2'b00, creep_lim});
    if (pos_err < 32'sd0) creep_speed = -creep_speed;
  end

  // host-written registers; other registers stay writable mid-homing
  // non-homing writes accepted
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cmd_code_reg          <= '0;
      type_code_reg         <= '0;
      first_latch_selector  <= '0;
      monitor_sel_reg       <= '0;
      acceleration_constant <= ACCEL_RESET;
      deceleration_constant <= DECEL_RESET;
      homing_velocity_one   <= VEL1_RESET;
      homing_velocity_two   <= VEL2_RESET;
      homing_direction_setting <= 1'b0;
    end else if (reg_wr && !mode_change) begin
      // a refused mode change leaves the running mode intact
      unique case (reg_addr)
        OFS_CTRL: begin
          cmd_code_reg  <= reg_wdata[7:0];
          type_code_reg <= reg_wdata[15:8];
        end
        OFS_LATCH: begin
          first_latch_selector <= reg_wdata[7:0];
          monitor_sel_reg      <= reg_wdata[15:8];
        end
        OFS_ACCEL: acceleration_constant <= reg_wdata[15:0];
        OFS_DECEL: deceleration_constant <= reg_wdata[15:0];
        OFS_VEL1:  homing_velocity_one   <= reg_wdata[15:0];
        OFS_VEL2:  homing_velocity_two   <= reg_wdata[15:0];
        OFS_DIR:   homing_direction_setting <= reg_wdata[0];
        default: ;  // read-only or unmapped: write ignored
      endcase
    end
  end

  // snapshot of the operation mode so later changes can be caught
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      type_at_start_reg  <= '0;
      latch_at_start_reg <= '0;
    end else if (start_pulse) begin
      type_at_start_reg  <= reg_wdata[15:8];
      latch_at_start_reg <= first_latch_selector;
    end
  end

  // sequencer; overtravel config inputs are deliberately not consulted
  // overtravel ignored, auto reverse
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= ST_IDLE;
    end else if (mode_change) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:       if (start_pulse) state_reg <= ST_RUN_OUT;
        ST_RUN_OUT:    if (far_limit && near_limit) state_reg <= ST_IDLE;
                       else if (far_limit) state_reg <= ST_BRAKE;
        ST_BRAKE:      if (ramp_stopped) state_reg <= ST_RUN_BACK;
        ST_RUN_BACK:   if (near_limit) state_reg <= ST_IDLE;
                       else if (!far_limit) state_reg <= ST_SEEK_INDEX;
        // index counts only once limit released
        ST_SEEK_INDEX: if (near_limit) state_reg <= ST_IDLE;
                       else if (index_pulse) state_reg <= ST_REPOSITION;
        ST_REPOSITION: if (ramp_stopped && pos_err == 32'sd0) state_reg <= ST_DONE;
        ST_DONE:       state_reg <= ST_IDLE;
        default:       state_reg <= ST_IDLE;
      endcase
    end
  end

  // tracks release of the far limit, read back at bit 16 of the error code register
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      limit_released_reg <= 1'b0;
    end else if (start_pulse) begin
      limit_released_reg <= 1'b0;
    end else if (state_reg == ST_RUN_BACK && !far_limit) begin
      limit_released_reg <= 1'b1;
    end
  end

  // speed target per phase; reposition brakes, then hops toward the index
  always_comb begin
    unique case (state_reg)
      ST_RUN_OUT:    ramp_target = v1_signed;
      ST_RUN_BACK:   ramp_target = v2_signed;
      ST_SEEK_INDEX: ramp_target = v2_signed;
      ST_REPOSITION: ramp_target = (!ramp_stopped || pos_err == 32'sd0) ? 18'sd0 : creep_speed;
      default:       ramp_target = 18'sd0;
    endcase
  end

  speed_ramp u_ramp (
    .clk        (clk),
    .rst_n_sync (rst_n_sync),
    .target     (ramp_target),
    .accel      (acceleration_constant),
    .decel      (deceleration_constant),
    .speed      (ramp_speed),
    .stopped    (ramp_stopped)
  );

  // position integrates speed; capture index, rebase to zero at the end
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      position_reg  <= '0;
      index_pos_reg <= '0;
    end else if (state_reg == ST_DONE) begin
      position_reg  <= position_reg - index_pos_reg;
      index_pos_reg <= '0;
    end else begin
      // speed is clamped near the index so overshoot stays bounded
      position_reg <= position_reg + 32'(ramp_speed);
      if (state_reg == ST_SEEK_INDEX && index_pulse && !near_limit)
        index_pos_reg <= position_reg;
    end
  end

  // status flags
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      in_progress_reg <= 1'b0;
      complete_reg    <= 1'b0;
    end else if (start_pulse) begin
      complete_reg    <= 1'b0;
      in_progress_reg <= 1'b1;
    end else if (state_reg == ST_DONE) begin
      complete_reg    <= 1'b1;
      in_progress_reg <= 1'b0;
    end else if (in_progress_reg && state_reg == ST_IDLE) begin
      in_progress_reg <= 1'b0;
    end
  end

  // error protections: sticky until the next start
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      homing_error_protection          <= 1'b0;
      network_command_error_protection <= 1'b0;
      cmd_error_reg                    <= 1'b0;
      err_code_reg                     <= ERR_NONE;
    end else if (mode_change) begin
      network_command_error_protection <= 1'b1;
      cmd_error_reg                    <= 1'b1;
      err_code_reg                     <= ERR_MODE_CHANGE;
    end else if (start_pulse) begin
      homing_error_protection          <= 1'b0;
      network_command_error_protection <= 1'b0;
      cmd_error_reg                    <= 1'b0;
      err_code_reg                     <= ERR_NONE;
    end else if ((state_reg == ST_RUN_OUT && far_limit && near_limit)
              || ((state_reg == ST_RUN_BACK || state_reg == ST_SEEK_INDEX) && near_limit)) begin
      homing_error_protection <= 1'b1;
    end
  end

  // motor speed output registered
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) motor_speed <= '0;
    else             motor_speed <= ramp_speed;
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        OFS_CTRL:     reg_rdata <= {16'h0000, type_code_reg, cmd_code_reg};
        OFS_LATCH:    reg_rdata <= {16'h0000, monitor_sel_reg, first_latch_selector};
        OFS_ACCEL:    reg_rdata <= {16'h0000, acceleration_constant};
        OFS_DECEL:    reg_rdata <= {16'h0000, deceleration_constant};
        OFS_VEL1:     reg_rdata <= {16'h0000, homing_velocity_one};
        OFS_VEL2:     reg_rdata <= {16'h0000, homing_velocity_two};
        OFS_DIR:      reg_rdata <= {31'h0, homing_direction_setting};
        OFS_STATUS:   reg_rdata <= {11'h0, network_command_error_protection,
                                    homing_error_protection, cmd_error_reg, complete_reg,
                                    in_progress_reg, type_code_reg, cmd_code_reg};
        OFS_POSITION: reg_rdata <= position_reg;
        // monitor: selector 0 position, 1 speed, 2 captured index
        OFS_MONITOR:  reg_rdata <= (monitor_sel_reg == 8'h01) ? 32'(ramp_speed) :
                                   (monitor_sel_reg == 8'h02) ? index_pos_reg : position_reg;
        OFS_ERRCODE:  reg_rdata <= {15'h0, limit_released_reg, err_code_reg};
        default:      reg_rdata <= '0;
      endcase
    end
  end
endmodule // homing_sequencer
`default_nettype wire

// ---- bench/homing_sequencer_sva.sv ----
// concurrent checks on the homing sequencer ports
`timescale 1ns/100ps
`default_nettype none
module homing_sequencer_sva
  import homing_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [3:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic               positive_limit_sensor,
  input wire logic               negative_limit_sensor,
  input wire logic               index_pulse,
  input wire logic               overtravel_inhibit_config,
  input wire logic               overtravel_stop_sequence,
  input wire logic signed [17:0] motor_speed,
  input wire logic               homing_error_protection,
  input wire logic               network_command_error_protection
);
  logic [7:0] last_cmd_reg;  // last command code written by the host
  logic       dir_reg;       // last homing direction written
  logic       start;         // a write that should launch homing
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  assign start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[15:0] == 16'h3617
                 && last_cmd_reg == CMD_NORMAL;
  // shadow of host writes, needed to know when a start is legal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_cmd_reg <= 8'h00;
      dir_reg      <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      last_cmd_reg <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == OFS_DIR) begin
      dir_reg <= reg_wdata[0];
    end
  end
  property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  property p_unmapped; reg_rd && reg_addr > OFS_ERRCODE |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_home_err_hold;
    homing_error_protection && !(reg_wr && reg_addr == OFS_CTRL) |=> homing_error_protection;
  endproperty
  a_home_err_hold: assert property (p_home_err_hold) else $error("homing error dropped");
  property p_net_err_hold;
    network_command_error_protection && !(reg_wr && reg_addr == OFS_CTRL)
      |=> network_command_error_protection;
  endproperty
  a_net_err_hold: assert property (p_net_err_hold) else $error("command error dropped");
  property p_net_echo;
    reg_rd && reg_addr == OFS_STATUS
      |=> reg_rdata[ST_NET_ERROR] == $past(network_command_error_protection);
  endproperty
  a_net_echo: assert property (p_net_echo) else $error("status net error mismatch");
  property p_home_echo;
    reg_rd && reg_addr == OFS_STATUS
      |=> reg_rdata[ST_HOME_ERROR] == $past(homing_error_protection);
  endproperty
  a_home_echo: assert property (p_home_echo) else $error("status homing error mismatch");
  property p_errcode;
    reg_rd && reg_addr == OFS_ERRCODE && network_command_error_protection
      |=> reg_rdata[15:0] == ERR_MODE_CHANGE;
  endproperty
  a_errcode: assert property (p_errcode) else $error("error code not 0104");
  property p_clear_done;
    start ##2 (reg_rd && reg_addr == OFS_STATUS)
      |=> !reg_rdata[ST_COMPLETE] && reg_rdata[ST_IN_PROGRESS];
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("complete not cleared at start");
  property p_run_out;
    start |-> ##[1:10] (dir_reg ? motor_speed > 0 : motor_speed < 0);
  endproperty
  a_run_out: assert property (p_run_out) else $error("no run-out motion after start");
  c_start: cover property (start);
  c_home_err: cover property ($rose(homing_error_protection));
  c_net_err: cover property ($rose(network_command_error_protection));
endmodule // homing_sequencer_sva
bind homing_sequencer homing_sequencer_sva i_homing_sequencer_sva (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .positive_limit_sensor(positive_limit_sensor),
  .negative_limit_sensor(negative_limit_sensor), .index_pulse(index_pulse),
  .overtravel_inhibit_config(overtravel_inhibit_config),
  .overtravel_stop_sequence(overtravel_stop_sequence), .motor_speed(motor_speed),
  .homing_error_protection(homing_error_protection),
  .network_command_error_protection(network_command_error_protection));
`default_nettype wire

// ---- bench/motion_plant.sv ----
// axis model: integrates commanded speed, makes limit and index levels
`timescale 1ns/100ps
`default_nettype none
module motion_plant #(
  parameter int LIM = 20000  // distance from zero to each limit sensor
) (
  input  wire logic               clk,
  input  wire logic signed [17:0] motor_speed,
  input  wire logic signed [31:0] idx_pos,
  input  wire logic               jam,
  output logic                    positive_limit_sensor,
  output logic                    negative_limit_sensor,
  output logic                    index_pulse
);
  logic signed [31:0] pos = 32'sh0;  // axis position in speed units
  // axis moves by the commanded speed every cycle
  always @(posedge clk) pos <= pos + 32'(motor_speed);
  // jam puts both sensors on, to provoke the fault path
  assign positive_limit_sensor = jam || pos > LIM;
  assign negative_limit_sensor = jam || pos < -LIM;
  assign index_pulse = pos >= idx_pos && pos < idx_pos + 32'sd64;
endmodule // motion_plant
`default_nettype wire

// ---- bench/homing_sequencer_tb.sv ----
// self-checking bench for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
module homing_sequencer_tb
  import homing_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, jam = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic signed [31:0] idx_pos = 32'sh0;
  logic pos_lim, neg_lim, idx;
  logic signed [17:0] motor_speed;
  logic home_err, net_err;
  int fails = 0, n_checks = 0, cyc = 0, k;
  // reset-value table: address beside expected read data
  logic [35:0] rows [8] = '{{OFS_ACCEL, 32'h1}, {OFS_DECEL, 32'h1}, {OFS_VEL1, 32'h100},
    {OFS_VEL2, 32'h10}, {OFS_POSITION, 32'h0}, {OFS_ERRCODE, 32'h0}, {4'hB, 32'h0},
    {4'hF, 32'h0}};
  homing_sequencer i_homing_sequencer (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .positive_limit_sensor(pos_lim), .negative_limit_sensor(neg_lim), .index_pulse(idx),
    .overtravel_inhibit_config(1'b1), .overtravel_stop_sequence(1'b1),
    .motor_speed(motor_speed), .homing_error_protection(home_err),
    .network_command_error_protection(net_err));
  motion_plant i_motion_plant (.clk(clk), .motor_speed(motor_speed), .idx_pos(idx_pos),
    .jam(jam), .positive_limit_sensor(pos_lim), .negative_limit_sensor(neg_lim),
    .index_pulse(idx));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // hang guard, a full homing run needs under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write cycle, strobe lowered at the edge that takes it
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // one read cycle, data taken in the following cycle only
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // start: normal code first, then the start code, then status at once
  task automatic launch();
    wr(OFS_CTRL, 32'h0010);
    wr(OFS_CTRL, 32'h3610);
    repeat (6) @(posedge clk);
    chk("speed before start", 32'(motor_speed), 32'h0);
    wr(OFS_CTRL, 32'h3617);
    rd(OFS_STATUS);
    chk("status after start", {11'h0, d[20:0]}, 32'h00013617);
  endtask
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // ordinary cases: reset values and unmapped reads
    foreach (rows[i]) begin
      rd(rows[i][35:32]);
      chk("reset value", d, rows[i][31:0]);
    end
    wr(OFS_ACCEL, 32'h8);
    wr(OFS_DECEL, 32'h8);
    wr(OFS_LATCH, 32'h0000);
    // full homing in both directions; index just inside the far limit each time
    for (int dir = 0; dir < 2; dir++) begin
      wr(OFS_DIR, 32'(dir));
      idx_pos <= dir ? 32'sd15000 : -32'sd15000;
      launch();
      repeat (40) @(posedge clk);
      chk("run-out sign", 32'(motor_speed[17]), dir ? 32'h0 : 32'h1);
      // monitor returns speed; latch selector kept
      wr(OFS_LATCH, 32'h0100);
      rd(OFS_MONITOR);
      chk("run-out speed", d, dir ? 32'(VEL1_RESET) : -32'(VEL1_RESET));
      wr(OFS_ACCEL, 32'h8);
      rd(OFS_STATUS);
      chk("busy after other write", 32'(d[ST_IN_PROGRESS]), 32'h1);
      k = 0;
      while (!d[ST_COMPLETE] && k < 3000) begin
        rd(OFS_STATUS);
        k++;
      end
      chk("busy at end", {30'h0, d[ST_IN_PROGRESS], d[ST_COMPLETE]}, 32'h1);
      chk("speed at end", 32'(motor_speed), 32'h0);
      chk("homing error", 32'(home_err), 32'h0);
      rd(OFS_POSITION);
      chk("position at index", d, 32'h0);
    end
    // changing the type code mid-homing must be refused
    launch();
    wr(OFS_CTRL, 32'h3117);
    rd(OFS_ERRCODE);
    chk("error code", {16'h0, d[15:0]}, {16'h0, ERR_MODE_CHANGE});
    chk("net error", 32'(net_err), 32'h1);
    rd(OFS_STATUS);
    // host reads the error state before going on
    chk("cancelled", {30'h0, d[ST_CMD_ERROR], d[ST_IN_PROGRESS]}, 32'h2);
    // both limits on during run-out cancels with homing error
    launch();
    chk("net error cleared", 32'(net_err), 32'h0);
    repeat (8) @(posedge clk);
    jam <= 1'b1;
    k = 0;
    while (home_err !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk("homing error", 32'(home_err), 32'h1);
    jam <= 1'b0;
    rd(OFS_STATUS);
    chk("busy after fault", 32'(d[ST_IN_PROGRESS]), 32'h0);
    // reset after the cancelled run clears the sticky fault and all status
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    chk("reset homing error", 32'(home_err), 32'h0);
    chk("reset speed", 32'(motor_speed), 32'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_STATUS);
    chk("status after reset", d, 32'h0);
    end_sim();
  end
endmodule // homing_sequencer_tb
`default_nettype wire
